// [hw/xbpi_pkg.sv]
/*
 * Package of the external bus pin interface: register offsets, field positions,
 * reset values, bus phase states and the request/pin carrier structs.
 * Assumes nothing of its surroundings.
 */
package xbpi_pkg;
	localparam logic [7:0] XBPI_PMR_OFF = 8'h00;
	localparam logic [7:0] XBPI_STAT_OFF = 8'h04;
	localparam logic [7:0] XBPI_P4DIR_OFF = 8'h08;
	localparam logic [7:0] XBPI_P4DAT_OFF = 8'h0c;
	localparam logic [7:0] XBPI_VECT_OFF = 8'h10;
	localparam logic [7:0] XBPI_IMEM_OFF = 8'h14;
	localparam int XBPI_MODE_LO = 0;
	localparam int XBPI_WAIT_BIT = 2;
	localparam int XBPI_CLKOUT_BIT = 7;
	localparam logic [7:0] XBPI_PMR_RST = 8'h00;
	localparam logic [7:0] XBPI_P4DIR_RST = 8'h00;
	localparam logic [23:0] XBPI_VECT_RST = 24'h00fffe;
	localparam logic [23:0] XBPI_IMEM_TOP_RST = 24'h000fff;
	localparam logic [1:0] XBPI_MODE_SINGLE = 2'h0;
	localparam logic [1:0] XBPI_MODE_EXPAND = 2'h1;
	localparam logic [1:0] XBPI_MODE_MPROC = 2'h2;
	localparam logic [2:0] XBPI_FAST_CYC = 3'h1;
	localparam logic [2:0] XBPI_WAIT_CYC = 3'h3;
	localparam logic [1:0] XBPI_RESP_OK = 2'h0;
	localparam logic [1:0] XBPI_RESP_SLV = 2'h2;

	typedef enum logic [3:0] {
		XBPI_IDLE = 4'b0001,
		XBPI_ADDR = 4'b0010,
		XBPI_DATA = 4'b0100,
		XBPI_HOLD = 4'b1000
	} xbpi_state_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] wdata;
		logic write;
		logic word;
	} xbpi_req_t;

	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] mid;
		logic [7:0] hi;
		logic [7:0] mid_oe;
		logic [7:0] hi_oe;
		logic [7:0] lo_oe;
	} xbpi_ports_t;
endpackage

// [hw/xbpi_top.sv]
/*
 * External bus pin interface: AXI4-Lite register slave, CPU access port and
 * the multiplexed 24-bit address/data bus with hold and ready handshakes.
 * Assumes one clock, synchronous pin inputs and an external address latch.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module xbpi_top
	import xbpi_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire xbpi_req_t CPU_REQ,
	input wire logic CPU_REQ_VALID,
	output logic CPU_REQ_READY,
	output logic [15:0] CPU_RDATA,
	output logic CPU_DONE,
	output logic [23:0] CPU_START_ADDR,
	output logic CPU_CLK_RUN,
	output logic WDOG_RUN,
	input wire logic BYTE_SEL,
	input wire logic MODE_STRAP,
	input wire logic HOLD_REQ_N,
	input wire logic READY_N,
	input wire logic [23:0] BUS_IN,
	output xbpi_ports_t BUS_OUT,
	output logic RW,
	output logic RW_OE,
	output logic UPPER_BYTE_SEL_N,
	output logic UPPER_BYTE_SEL_N_OE,
	output logic LATCH_STROBE,
	output logic BUS_GRANT_ACK_N,
	output logic DATA_STROBE_N,
	output logic CLK_OUT,
	output logic CLK_OUT_OE
);
	logic [7:0] proc_mode_reg;
	logic [7:0] p4dir_reg;
	logic [7:0] p4dat_reg;
	logic [23:0] vect_reg;
	logic [23:0] imem_top_reg;
	logic strap_reg;
	logic started_reg;
	logic [1:0] mode;
	logic ext_mode;
	xbpi_state_t state_reg;
	xbpi_req_t req_reg;
	logic [2:0] cnt_reg;
	logic [15:0] rdata_reg;
	logic done_reg;
	logic clk_div_reg;
	logic clkout_en_reg;
	logic ext_cycle;
	logic internal_hit;
	logic odd_byte;
	logic [7:0] aw_addr_reg;
	logic aw_full_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_full_reg;
	logic [31:0] rd_mux;
	logic rd_ok;
	logic wr_ok;

	// Strap sampled on the first clock edge after reset is released, then held until the next reset.
	// strap mode select
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			strap_reg <= 1'b0;
			started_reg <= 1'b0;
		end else begin
			if (!started_reg) begin
				strap_reg <= MODE_STRAP;
			end
			started_reg <= 1'b1;
		end
	end
	assign mode = strap_reg ? XBPI_MODE_MPROC : proc_mode_reg[XBPI_MODE_LO +: 2];
	assign ext_mode = started_reg && (mode == XBPI_MODE_EXPAND || mode == XBPI_MODE_MPROC);

	assign CPU_START_ADDR = vect_reg;

	assign internal_hit = (mode == XBPI_MODE_SINGLE) || (CPU_REQ.addr <= imem_top_reg);

	// AXI write path: address and data are taken in either order.
	assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_full_reg && !S_AXI_BVALID;
	always_comb begin
		wr_ok = 1'b1;
		case (aw_addr_reg)
			XBPI_PMR_OFF, XBPI_P4DIR_OFF, XBPI_P4DAT_OFF, XBPI_VECT_OFF, XBPI_IMEM_OFF: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			aw_addr_reg <= 8'h00;
			aw_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			w_full_reg <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= XBPI_RESP_OK;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_addr_reg <= S_AXI_AWADDR;
				aw_full_reg <= 1'b1;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
				w_full_reg <= 1'b1;
			end
			if (aw_full_reg && w_full_reg) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? XBPI_RESP_OK : XBPI_RESP_SLV;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			proc_mode_reg <= XBPI_PMR_RST;
			p4dir_reg <= XBPI_P4DIR_RST;
			p4dat_reg <= 8'h00;
			vect_reg <= XBPI_VECT_RST;
			imem_top_reg <= XBPI_IMEM_TOP_RST;
		end else if (aw_full_reg && w_full_reg && w_strb_reg != 4'h0) begin
			case (aw_addr_reg)
				XBPI_PMR_OFF: proc_mode_reg <= w_data_reg[7:0];
				XBPI_P4DIR_OFF: p4dir_reg <= w_data_reg[7:0];
				XBPI_P4DAT_OFF: p4dat_reg <= w_data_reg[7:0];
				XBPI_VECT_OFF: vect_reg <= w_data_reg[23:0];
				XBPI_IMEM_OFF: imem_top_reg <= w_data_reg[23:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		case (S_AXI_ARADDR)
			XBPI_PMR_OFF: rd_mux = {24'h000000, proc_mode_reg};
			XBPI_STAT_OFF: rd_mux = {24'h000000, state_reg, 1'b0, strap_reg, ext_mode,
				BUS_GRANT_ACK_N};
			XBPI_P4DIR_OFF: rd_mux = {24'h000000, p4dir_reg};
			XBPI_P4DAT_OFF: rd_mux = {24'h000000, p4dat_reg[7:2], READY_N, HOLD_REQ_N};
			XBPI_VECT_OFF: rd_mux = {8'h00, vect_reg};
			XBPI_IMEM_OFF: rd_mux = {8'h00, imem_top_reg};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= XBPI_RESP_OK;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_mux;
			S_AXI_RRESP <= rd_ok ? XBPI_RESP_OK : XBPI_RESP_SLV;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			clk_div_reg <= 1'b0;
			clkout_en_reg <= 1'b0;
		end else begin
			clk_div_reg <= !clk_div_reg;
			if (DATA_STROBE_N) begin
				clkout_en_reg <= proc_mode_reg[XBPI_CLKOUT_BIT];
			end
		end
	end
	assign CLK_OUT_OE = clkout_en_reg;
	assign CLK_OUT = clkout_en_reg & clk_div_reg;

	assign CPU_CLK_RUN = (state_reg != XBPI_HOLD);
	assign WDOG_RUN = (state_reg != XBPI_HOLD);

	assign CPU_REQ_READY = (state_reg == XBPI_IDLE) && HOLD_REQ_N;
	assign odd_byte = req_reg.addr[0];
	assign ext_cycle = ext_mode && (req_reg.write || !internal_hit);

	// Bus sequencer: idle, address phase, data phase, hold.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= XBPI_IDLE;
			req_reg <= '0;
			cnt_reg <= 3'h0;
			rdata_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				XBPI_IDLE: begin
					if (!HOLD_REQ_N && ext_mode) begin
						state_reg <= XBPI_HOLD;
					end else if (CPU_REQ_VALID && CPU_REQ_READY) begin
						req_reg <= CPU_REQ;
						// internal read never uses the bus
						if (ext_mode && (CPU_REQ.write || !internal_hit)) begin
							state_reg <= XBPI_ADDR;
						end else begin
							rdata_reg <= 16'h0000;
							done_reg <= 1'b1;
						end
					end
				end
				XBPI_ADDR: begin
					state_reg <= XBPI_DATA;
					cnt_reg <= proc_mode_reg[XBPI_WAIT_BIT] ? XBPI_FAST_CYC : XBPI_WAIT_CYC;
				end
				XBPI_DATA: begin
					if (READY_N) begin
						if (cnt_reg == 3'h0) begin
							state_reg <= XBPI_IDLE;
							done_reg <= 1'b1;
							if (BYTE_SEL) begin
								rdata_reg <= {8'h00, BUS_IN[23:16]};
							end else begin
								rdata_reg <= {BUS_IN[15:8], BUS_IN[23:16]};
							end
						end else begin
							cnt_reg <= cnt_reg - 3'h1;
						end
					end
				end
				XBPI_HOLD: begin
					if (HOLD_REQ_N) begin
						state_reg <= XBPI_IDLE;
					end
				end
				default: state_reg <= XBPI_IDLE;
			endcase
		end
	end
	assign CPU_RDATA = rdata_reg;
	assign CPU_DONE = done_reg;

	assign LATCH_STROBE = (state_reg == XBPI_ADDR);
	// latch strobe low keeps external address
	assign DATA_STROBE_N = (state_reg != XBPI_DATA);
	assign BUS_GRANT_ACK_N = (state_reg != XBPI_HOLD);
	assign RW_OE = ext_mode && (state_reg != XBPI_HOLD);
	assign UPPER_BYTE_SEL_N_OE = RW_OE;
	assign RW = !(ext_cycle && req_reg.write && state_reg != XBPI_IDLE);
	assign UPPER_BYTE_SEL_N = !(odd_byte || (req_reg.word && !BYTE_SEL));

	always_comb begin
		BUS_OUT = '0;
		if (RW_OE) begin
			BUS_OUT.lo = req_reg.addr[7:0];
			BUS_OUT.lo_oe = 8'hff;
			BUS_OUT.mid_oe = 8'hff;
			BUS_OUT.hi_oe = 8'hff;
			// middle port address or odd data
			if (DATA_STROBE_N || BYTE_SEL) begin
				BUS_OUT.mid = req_reg.addr[15:8];
			end else begin
				BUS_OUT.mid = req_reg.wdata[15:8];
				BUS_OUT.mid_oe = {8{req_reg.write}};
			end
			// upper port address or even data
			// 8-bit bus uses upper port only
			if (DATA_STROBE_N) begin
				BUS_OUT.hi = req_reg.addr[23:16];
			end else begin
				BUS_OUT.hi = (BYTE_SEL && odd_byte) ? req_reg.wdata[15:8] : req_reg.wdata[7:0];
				BUS_OUT.hi_oe = {8{req_reg.write}};
			end
		end
	end

	hold_ack_a: assert property (@(posedge CLK) disable iff (!NRST)
		!HOLD_REQ_N && state_reg == XBPI_IDLE && ext_mode |=> !BUS_GRANT_ACK_N)
		else $error("hold not acknowledged");
	hold_float_a: assert property (@(posedge CLK) disable iff (!NRST)
		!BUS_GRANT_ACK_N |-> !RW_OE && !LATCH_STROBE && BUS_OUT.hi_oe == 8'h00)
		else $error("bus driven during hold");
	hold_strobe_a: assert property (@(posedge CLK) disable iff (!NRST)
		!BUS_GRANT_ACK_N |-> DATA_STROBE_N && !CPU_CLK_RUN)
		else $error("strobe or cpu clock active in hold");
	wdog_stop_a: assert property (@(posedge CLK) disable iff (!NRST)
		!HOLD_REQ_N && ext_mode && state_reg == XBPI_IDLE |=> !WDOG_RUN)
		else $error("watchdog runs in hold");
	sequence addr_phase_s;
		LATCH_STROBE && DATA_STROBE_N;
	endsequence
	sequence data_phase_s;
		!LATCH_STROBE && !DATA_STROBE_N;
	endsequence
	bus_phase_a: assert property (@(posedge CLK) disable iff (!NRST)
		addr_phase_s |=> data_phase_s)
		else $error("address phase not followed by data phase");
	ready_freeze_a: assert property (@(posedge CLK) disable iff (!NRST)
		!DATA_STROBE_N && !READY_N |=> !DATA_STROBE_N && $stable(BUS_OUT))
		else $error("bus moved while not ready");
	mid_addr_a: assert property (@(posedge CLK) disable iff (!NRST)
		LATCH_STROBE && RW_OE |-> BUS_OUT.mid == req_reg.addr[15:8]
			&& BUS_OUT.hi == req_reg.addr[23:16])
		else $error("address missing in address phase");
	sequence wait_addr_s;
		LATCH_STROBE && !proc_mode_reg[XBPI_WAIT_BIT];
	endsequence
	wait_len_a: assert property (@(posedge CLK) disable iff (!NRST)
		wait_addr_s ##1 READY_N [*4] |=> DATA_STROBE_N)
		else $error("wait cycle length wrong");
	wait_low_a: assert property (@(posedge CLK) disable iff (!NRST)
		wait_addr_s |=> (!DATA_STROBE_N) [*4])
		else $error("wait data phase too short");
	strap_mode_a: assert property (@(posedge CLK) disable iff (!NRST)
		strap_reg && started_reg |-> ext_mode)
		else $error("strap did not force microprocessor mode");
endmodule // xbpi_top
`default_nettype wire

// [testbench/testbench.sv]
/*
 * Self-checking testbench of the external bus pin interface with an
 * AXI4-Lite master, a CPU request driver and a reference byte memory.
 * Assumes the partner memory model in xbpi_ext_mem.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench
	import xbpi_pkg::*;
;
	logic CLK = 1'b0, NRST = 1'b0, BYTE_SEL = 1'b0, MODE_STRAP = 1'b0, HOLD_REQ_N = 1'b1;
	logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
	logic S_AXI_RREADY = 0, CPU_REQ_VALID = 0;
	logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, seed = 32'h1, r;
	logic [3:0] S_AXI_WSTRB = 4'hf, stall = 4'h0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
	xbpi_req_t CPU_REQ = '0;
	logic CPU_REQ_READY, CPU_DONE, CPU_CLK_RUN, WDOG_RUN, READY_N, CLK_OUT, CLK_OUT_OE;
	logic [15:0] CPU_RDATA, wd;
	logic [23:0] CPU_START_ADDR, BUS_IN, a;
	xbpi_ports_t BUS_OUT;
	logic RW, RW_OE, UPPER_BYTE_SEL_N, UPPER_BYTE_SEL_N_OE, LATCH_STROBE, BUS_GRANT_ACK_N;
	logic DATA_STROBE_N, ck_q;
	logic [7:0] ref_mem [logic [23:0]];
	int errors = 0, n_tests = 0, lat, lat_f, lat_w;
	xbpi_top dut (.CLK(CLK), .NRST(NRST), .S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .CPU_REQ(CPU_REQ), .CPU_REQ_VALID(CPU_REQ_VALID),
		.CPU_REQ_READY(CPU_REQ_READY), .CPU_RDATA(CPU_RDATA), .CPU_DONE(CPU_DONE),
		.CPU_START_ADDR(CPU_START_ADDR), .CPU_CLK_RUN(CPU_CLK_RUN), .WDOG_RUN(WDOG_RUN),
		.BYTE_SEL(BYTE_SEL), .MODE_STRAP(MODE_STRAP), .HOLD_REQ_N(HOLD_REQ_N),
		.READY_N(READY_N), .BUS_IN(BUS_IN), .BUS_OUT(BUS_OUT), .RW(RW), .RW_OE(RW_OE),
		.UPPER_BYTE_SEL_N(UPPER_BYTE_SEL_N), .UPPER_BYTE_SEL_N_OE(UPPER_BYTE_SEL_N_OE),
		.LATCH_STROBE(LATCH_STROBE), .BUS_GRANT_ACK_N(BUS_GRANT_ACK_N),
		.DATA_STROBE_N(DATA_STROBE_N), .CLK_OUT(CLK_OUT), .CLK_OUT_OE(CLK_OUT_OE));
	xbpi_ext_mem u_mem (.CLK(CLK), .BUS_OUT(BUS_OUT), .RW(RW),
		.UPPER_BYTE_SEL_N(UPPER_BYTE_SEL_N), .LATCH_STROBE(LATCH_STROBE),
		.DATA_STROBE_N(DATA_STROBE_N), .BYTE_SEL(BYTE_SEL), .STALL(stall),
		.READY_N(READY_N), .BUS_IN(BUS_IN));
	always #2 CLK = ~CLK;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic do_reset();
		NRST <= 1'b0;
		repeat (8) @(posedge CLK);
		NRST <= 1'b1;
		repeat (3) @(posedge CLK);
	endtask
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
		logic aw, w, ta, tw;
		aw = 1'b1;
		w = 1'b1;
		S_AXI_AWADDR <= ad;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		while (aw || w) begin
			@(negedge CLK);
			ta = aw && S_AXI_AWREADY === 1'b1;
			tw = w && S_AXI_WREADY === 1'b1;
			@(posedge CLK);
			if (ta) begin
				S_AXI_AWVALID <= 1'b0;
				aw = 1'b0;
			end
			if (tw) begin
				S_AXI_WVALID <= 1'b0;
				w = 1'b0;
			end
		end
		S_AXI_BREADY <= 1'b1;
		do @(negedge CLK); while (S_AXI_BVALID !== 1'b1);
		@(posedge CLK);
		S_AXI_BREADY <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
		S_AXI_ARADDR <= ad;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(negedge CLK); while (S_AXI_ARREADY !== 1'b1);
		@(posedge CLK);
		S_AXI_ARVALID <= 1'b0;
		do @(negedge CLK); while (S_AXI_RVALID !== 1'b1);
		d = S_AXI_RDATA;
		rs = S_AXI_RRESP;
		@(posedge CLK);
	endtask
	task automatic cpu(input logic [23:0] ad, input logic [15:0] d, input logic wr, wo,
		output int l);
		CPU_REQ <= '{addr: ad, wdata: d, write: wr, word: wo};
		CPU_REQ_VALID <= 1'b1;
		do @(negedge CLK); while (CPU_REQ_READY !== 1'b1);
		@(posedge CLK);
		CPU_REQ_VALID <= 1'b0;
		l = 0;
		do begin
			@(negedge CLK);
			l++;
		end while (CPU_DONE !== 1'b1);
		@(posedge CLK);
	endtask
	task automatic ext_wr(input logic [23:0] ad, input logic [15:0] d, input logic wo);
		cpu(ad, d, 1'b1, wo, lat);
		if (!ad[0])
			ref_mem[ad] = d[7:0];
		if (ad[0] || wo)
			ref_mem[ad | 24'h1] = d[15:8];
		foreach (ref_mem[k]) chk("ext_mem", u_mem.rd_byte(k), ref_mem[k]);
		chk("latched_addr", u_mem.adr, ad);
		chk("rw_write", u_mem.rw_seen, 1'b0);
	endtask
	initial begin
		do_reset();
		chk("oe_reset", {BUS_OUT.lo_oe, BUS_OUT.mid_oe, BUS_OUT.hi_oe, RW_OE}, '0);
		chk("start_addr", CPU_START_ADDR, XBPI_VECT_RST);
		axi_rd(XBPI_PMR_OFF, r, resp);
		chk("pmr_reset", r, XBPI_PMR_RST);
		axi_rd(XBPI_VECT_OFF, r, resp);
		chk("vector", r, XBPI_VECT_RST);
		axi_rd(XBPI_IMEM_OFF, r, resp);
		chk("imem_top", r, XBPI_IMEM_TOP_RST);
		axi_rd(XBPI_P4DAT_OFF, r, resp);
		chk("p4_live", r[1:0], {READY_N, HOLD_REQ_N});
		HOLD_REQ_N <= 1'b0;
		axi_rd(XBPI_P4DAT_OFF, r, resp);
		chk("p4_live_hold", r[1:0], 2'b10);
		HOLD_REQ_N <= 1'b1;
		axi_rd(8'h20, r, resp);
		chk("unmapped", {resp, r}, {XBPI_RESP_SLV, 32'h0});
		for (int m = 2; m >= 0; m--) begin
			axi_wr(XBPI_PMR_OFF, m);
			axi_rd(XBPI_STAT_OFF, r, resp);
			chk("ext_mode", r[1], m != 0);
		end
		axi_wr(XBPI_PMR_OFF, 32'h1);
		r = rnd();
		a = {8'h10, r[15:1], 1'b0};
		wd = r[31:16];
		ext_wr(a, wd, 1'b1);
		lat_w = lat;
		cpu(a, 16'h0, 1'b0, 1'b1, lat);
		chk("rdata", CPU_RDATA, {ref_mem[a | 24'h1], ref_mem[a]});
		chk("rw_read", u_mem.rw_seen, 1'b1);
		axi_wr(XBPI_PMR_OFF, 32'h5);
		ext_wr(a + 24'h2, ~wd, 1'b1);
		lat_f = lat;
		chk("lat_wait", lat_w, 6);
		chk("lat_fast", lat_f, 4);
		ext_wr(a + 24'h5, r[23:8], 1'b0);
		chk("upper_sel", u_mem.ubs_seen, 1'b0);
		stall <= 4'h3;
		ext_wr(a + 24'h6, r[15:0], 1'b1);
		chk("ready_lat", lat, lat_f + 3);
		stall <= 4'h0;
		ext_wr(24'h000100, wd, 1'b1);
		cpu(24'h000100, 16'h0, 1'b0, 1'b1, lat);
		chk("int_rdata", CPU_RDATA, 16'h0);
		BYTE_SEL <= 1'b1;
		cpu(24'h000100, 16'h0, 1'b0, 1'b1, lat);
		chk("int_lat", lat, 1);
		r = rnd();
		ext_wr(a + 24'h9, r[15:0], 1'b0);
		a = a + 24'ha;
		ext_wr(a, r[31:16], 1'b0);
		chk("mid_addr", u_mem.mid_seen, a[15:8]);
		BYTE_SEL <= 1'b0;
		HOLD_REQ_N <= 1'b0;
		repeat (4) @(posedge CLK);
		@(negedge CLK);
		chk("hold_ack", BUS_GRANT_ACK_N, 1'b0);
		chk("hold_float", {BUS_OUT.lo_oe, BUS_OUT.mid_oe, BUS_OUT.hi_oe, RW_OE,
			UPPER_BYTE_SEL_N_OE, LATCH_STROBE}, '0);
		chk("hold_stop", {DATA_STROBE_N, CPU_CLK_RUN, WDOG_RUN, CPU_REQ_READY}, 4'h8);
		@(posedge CLK);
		HOLD_REQ_N <= 1'b1;
		repeat (3) @(posedge CLK);
		@(negedge CLK);
		chk("hold_end", {BUS_GRANT_ACK_N, CPU_CLK_RUN, WDOG_RUN}, 3'h7);
		@(posedge CLK);
		axi_wr(XBPI_PMR_OFF, 32'h85);
		repeat (4) @(posedge CLK);
		@(negedge CLK);
		chk("clk_out_oe", CLK_OUT_OE, 1'b1);
		ck_q = CLK_OUT;
		@(negedge CLK);
		chk("clk_out_toggle", CLK_OUT, !ck_q);
		@(posedge CLK);
		MODE_STRAP <= 1'b1;
		do_reset();
		axi_rd(XBPI_STAT_OFF, r, resp);
		chk("strap_mode", r[1], 1'b1);
		r = rnd();
		ext_wr(a + 24'hc, r[15:0], 1'b1);
		report_and_stop();
	end
	initial begin
		#20000;
		errors++;
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire

// [testbench/xbpi_ext_mem.sv]
/*
 * Partner model: byte-wide external memory with an address latch and a
 * ready line that can stall a chosen number of cycles per data phase.
 * Assumes the bus pins are split into output, enable and input level.
 */
`timescale 1ns/100ps
`default_nettype none
module xbpi_ext_mem
	import xbpi_pkg::*;
(
	input wire logic CLK,
	input wire xbpi_ports_t BUS_OUT,
	input wire logic RW,
	input wire logic UPPER_BYTE_SEL_N,
	input wire logic LATCH_STROBE,
	input wire logic DATA_STROBE_N,
	input wire logic BYTE_SEL,
	input wire logic [3:0] STALL,
	output logic READY_N,
	output logic [23:0] BUS_IN
);
	logic [7:0] mem [logic [23:0]];
	logic [23:0] adr;
	logic [23:0] last = '0;
	logic [23:0] mdrv;
	logic rw_seen = 1'b0;
	logic ubs_seen = 1'b1;
	logic [7:0] mid_seen = '0;
	logic ds_q = 1'b1;
	logic [3:0] cnt = '0;
	wire logic [23:0] oe = {BUS_OUT.hi_oe, BUS_OUT.mid_oe, BUS_OUT.lo_oe};
	wire logic [23:0] pout = {BUS_OUT.hi, BUS_OUT.mid, BUS_OUT.lo};
	function automatic logic [7:0] rd_byte(input logic [23:0] k);
		return mem.exists(k) ? mem[k] : 8'h00;
	endfunction
	always_latch begin
		if (LATCH_STROBE)
			adr <= pout;
	end
	// Released lines show the inverse of their last level, never a stale value.
	always @* begin
		if (!DATA_STROBE_N && RW && BYTE_SEL)
			mdrv = {rd_byte(adr), ~last[15:0]};
		else if (!DATA_STROBE_N && RW)
			mdrv = {rd_byte({adr[23:1], 1'b0}), rd_byte({adr[23:1], 1'b1}), ~last[7:0]};
		else
			mdrv = ~last;
	end
	assign BUS_IN = (oe & pout) | (~oe & mdrv);
	always @(posedge CLK) begin
		last <= BUS_IN;
		if (!DATA_STROBE_N) begin
			rw_seen <= RW;
			ubs_seen <= UPPER_BYTE_SEL_N;
			mid_seen <= BUS_OUT.mid;
			if (!RW && BYTE_SEL)
				mem[adr] = BUS_OUT.hi;
			if (!RW && !BYTE_SEL && !adr[0])
				mem[adr] = BUS_OUT.hi;
			if (!RW && !BYTE_SEL && !UPPER_BYTE_SEL_N)
				mem[adr | 24'h1] = BUS_OUT.mid;
		end
	end
	always @(posedge CLK) begin
		ds_q <= DATA_STROBE_N;
		if (ds_q && !DATA_STROBE_N)
			cnt <= STALL;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	assign READY_N = (cnt == 4'h0);
endmodule // xbpi_ext_mem
`default_nettype wire
